//--- rtl/sysif_regs.svh
`ifndef SYSIF_REGS_SVH
`define SYSIF_REGS_SVH
`define WBUF_DEPTH       3'd4
`define BLOCK_WORDS      4'd8
`define BLOCK_DWORDS     4'd4
`define REPEAT_CYCLES    2'd2
`define CMD_READ         9'h000
`define CMD_WRITE        9'h080
`define CMD_BLOCK_BIT    3
`define CMD_DATA         9'h100
`define CMD_DATA_EOD     9'h108
`define CMD_NULL         9'h1F0
`define CMD_RESP_DATA    9'h100
`define CMD_RESP_EOD     9'h108
`define MODE_COMPAT      2'h0
`define MODE_PIPE        2'h2
`define MODE_REISSUE     2'h3
`endif

//--- rtl/sysif_pkg.sv
package sysif_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_rdreq = 3'b001,
    st_rdwt  = 3'b010,
    st_wraddr = 3'b011,
    st_wrdata = 3'b100,
    st_slave = 3'b101
  } bus_state_e;
  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic [3:0]  nbytes;
    logic        block;
  } wr_entry_s;
endpackage : sysif_pkg

//--- rtl/wr_entry_buf.sv
`timescale 1ns/1ps
// Two-entry skid buffer; a stall by the bus side loses no entry
module wr_entry_buf
  import sysif_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      nrst,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire wr_entry_s in_data,
  output logic           out_valid,
  input  wire logic      out_ready,
  output wr_entry_s      out_data
);
  typedef struct packed {
    wr_entry_s [1:0] mem;
    logic      [1:0] cnt;
    logic            rd;
  } buf_s;
  buf_s st;
  buf_s next_st;
  logic push;
  logic pop;
  logic [1:0] cnt_after_pop;
  assign in_ready  = (st.cnt != 2'd2);
  assign out_valid = (st.cnt != 2'd0);
  assign out_data  = st.mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  assign cnt_after_pop = pop ? st.cnt - 2'd1 : st.cnt;
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.rd ^ st.cnt[0] ^ st.cnt[1]] = in_data;
    end
    if (pop)
    begin
      next_st.rd = ~st.rd;
    end
    next_st.cnt = push ? cnt_after_pop + 2'd1 : cnt_after_pop;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule : wr_entry_buf

//--- rtl/sysif_bridge.sv
`timescale 1ns/1ps
`include "sysif_regs.svh"
// Operation
// - All memory writes pass four-entry write buffer
// - Line writeback fills buffer, core continues on 64-bit bus
// - Single transfers 1-8 bytes, blocks eight words
// - Low address bits start byte, command sizes
// - Width sets beats; 32-bit splits wide singles
// - Sample accept inputs before dropping address
// - External request answered by release, slave
// - Valid out only while driving valid
// - One outstanding request at a time
// - Requests flow both directions
// - Read: address, then release, agent returns
// - Re-issue: write every two cycles, recheck; on a failed recheck the code drops valid and waits, no re-issue
// - Pipelined: one extra write after deassert
// - Only read response and null accepted
module sysif_bridge
  import sysif_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        cfg_bus32,
  input  wire logic [1:0]  cfg_write_mode,
  input  wire logic        wr_req_valid,
  output logic             wr_req_ready,
  input  wire logic [63:0] wr_req_addr,
  input  wire logic [63:0] wr_req_data,
  input  wire logic [3:0]  wr_req_nbytes,
  input  wire logic        wr_req_block,
  input  wire logic        rd_req_valid,
  output logic             rd_req_ready,
  input  wire logic [63:0] rd_req_addr,
  input  wire logic [3:0]  rd_req_nbytes,
  input  wire logic        rd_req_block,
  output logic             rd_data_valid,
  output logic [63:0]      rd_data,
  output logic             rd_done,
  output logic             wbuf_empty,
  input  wire logic [63:0] sys_addr_data_bus_in,
  output logic [63:0]      sys_addr_data_bus_out,
  output logic             sys_addr_data_bus_oe,
  input  wire logic [8:0]  sys_command_bus_in,
  output logic [8:0]       sys_command_bus_out,
  output logic             sys_command_bus_oe,
  input  wire logic        read_accept_n,
  input  wire logic        write_accept_n,
  input  wire logic        ext_bus_request_n,
  output logic             release_n,
  output logic             proc_valid_n,
  input  wire logic        agent_valid_n
);
  //////////////////////////////////////////////////////////////////////
  typedef struct packed {
    bus_state_e  state;
    logic        bus32;
    logic [1:0]  wmode;
    logic        cfg_done;
    logic [63:0] ad_out;
    logic [8:0]  cmd_out;
    logic        drive;
    logic        valid;
    logic        rel;
    logic [1:0]  acc_hist;
    logic [2:0]  beat;
    logic        half;
    logic        extra_ok;
    logic [3:0]  beats_left;
    logic        rd_v;
    logic [63:0] rd_d;
    logic        rd_end;
    logic [2:0]  wcount;
  } core_s;
  core_s st;
  core_s next_st;
  wr_entry_s in_entry;
  wr_entry_s head;
  wr_entry_s mid_data;
  logic      mid_valid;
  logic      mid_ready;
  logic      head_valid;
  logic      head_pop;
  logic      buf_in_ready;
  logic      wide_single;
  logic      issue_ok;
  logic      last_beat;
  logic      agent_ok;
  //////////////////////////////////////////////////////////////////////
  // Core sees room only while fewer than four entries are held
  assign in_entry = '{addr: wr_req_addr, data: wr_req_data, nbytes: wr_req_nbytes,
                      block: wr_req_block};
  assign wr_req_ready = buf_in_ready && (st.wcount < `WBUF_DEPTH);
  assign wbuf_empty   = (st.wcount == 3'd0);
  // Two skid stages in series give the four held entries
  wr_entry_buf u_wbuf_in (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (wr_req_valid && wr_req_ready),
    .in_ready  (buf_in_ready),
    .in_data   (in_entry),
    .out_valid (mid_valid),
    .out_ready (mid_ready),
    .out_data  (mid_data)
  );
  wr_entry_buf u_wbuf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (mid_valid),
    .in_ready  (mid_ready),
    .in_data   (mid_data),
    .out_valid (head_valid),
    .out_ready (head_pop),
    .out_data  (head)
  );
  // Block writeback presented as four consecutive entries on a 64-bit bus, eight on a 32-bit bus
  assign rd_req_ready = (st.state == st_idle) && st.cfg_done && ext_bus_request_n
                        && !head_valid;
  assign wide_single = st.bus32 && !head.block && (head.nbytes > 4'd4);
  // Issue rule: accept seen two cycles back and now; pipelined grants one more
  assign issue_ok = (!write_accept_n && !st.acc_hist[1])
                    || ((st.wmode == `MODE_PIPE) && st.extra_ok);
  assign last_beat = (st.beats_left == 4'd1);
  assign agent_ok = !agent_valid_n && st.rel;
  assign sys_addr_data_bus_out = st.ad_out;
  assign sys_addr_data_bus_oe  = st.drive;
  assign sys_command_bus_out   = st.cmd_out;
  assign sys_command_bus_oe    = st.drive;
  assign proc_valid_n          = !st.valid;
  assign release_n             = !st.rel;
  assign rd_data_valid         = st.rd_v;
  assign rd_data               = st.rd_d;
  assign rd_done               = st.rd_end;
  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    head_pop = 1'b0;
    next_st.rd_v = 1'b0;
    next_st.rd_end = 1'b0;
    next_st.acc_hist = {st.acc_hist[0], write_accept_n};
    if (!st.cfg_done)
    begin
      next_st.bus32 = cfg_bus32;
      next_st.wmode = cfg_write_mode;
      next_st.cfg_done = 1'b1;
    end
    case (st.state)
      st_idle:
      begin
        next_st.valid = 1'b0;
        next_st.drive = st.cfg_done;
        if (!ext_bus_request_n)
        begin
          next_st.state = st_slave;
          next_st.drive = 1'b0;
          next_st.rel = 1'b1;
        end
        else if (st.cfg_done && head_valid && (issue_ok || st.wmode == `MODE_COMPAT))
        begin
          next_st.state = st_wraddr;
          next_st.ad_out = head.addr;
          next_st.cmd_out = `CMD_WRITE | {5'h00, head.block, head.nbytes[2:0]};
          next_st.valid = 1'b1;
          next_st.extra_ok = !write_accept_n;
          next_st.half = 1'b0;
          next_st.beats_left = head.block ? (st.bus32 ? `BLOCK_WORDS : `BLOCK_DWORDS)
                               : (wide_single ? 4'd2 : 4'd1);
        end
        else if (st.cfg_done && rd_req_valid)
        begin
          next_st.state = st_rdreq;
          next_st.ad_out = rd_req_addr;
          next_st.cmd_out = `CMD_READ | {5'h00, rd_req_block, rd_req_nbytes[2:0]};
          next_st.valid = 1'b1;
          next_st.beats_left = rd_req_block ? (st.bus32 ? `BLOCK_WORDS : `BLOCK_DWORDS)
                               : ((st.bus32 && rd_req_nbytes > 4'd4) ? 4'd2 : 4'd1);
        end
      end
      st_rdreq:
      begin
        // Address held until read accept seen
        if (!read_accept_n)
        begin
          next_st.state = st_rdwt;
          next_st.valid = 1'b0;
          next_st.drive = 1'b0;
          next_st.rel = 1'b1;
        end
      end
      st_rdwt:
      begin
        // Null keeps the bus but carries no data
        if (agent_ok && sys_command_bus_in[8] && sys_command_bus_in != `CMD_NULL)
        begin
          next_st.rd_v = 1'b1;
          next_st.rd_d = sys_addr_data_bus_in;
          next_st.beats_left = st.beats_left - 4'd1;
          if (last_beat || sys_command_bus_in == `CMD_RESP_EOD)
          begin
            next_st.rd_end = 1'b1;
            next_st.rel = 1'b0;
            next_st.state = st_idle;
          end
        end
      end
      st_wraddr:
      begin
        // Address valid one cycle while issue_ok sampled; otherwise valid drops and data waits for issue_ok, no re-issue
        if (issue_ok)
        begin
          next_st.state = st_wrdata;
          next_st.extra_ok = 1'b0;
          next_st.ad_out = (st.bus32 && st.half) ? {32'h00000000, head.data[63:32]}
                           : head.data;
          next_st.cmd_out = last_beat ? `CMD_DATA_EOD : `CMD_DATA;
        end
        else
        begin
          next_st.valid = 1'b0;
        end
      end
      st_wrdata:
      begin
        // Valid low means the next entry is not yet on the bus: load it first
        if (!st.valid)
        begin
          if (head_valid)
          begin
            next_st.valid = 1'b1;
            next_st.ad_out = head.data;
            next_st.cmd_out = last_beat ? `CMD_DATA_EOD : `CMD_DATA;
          end
        end
        else if (st.bus32 && !head.block && !st.half && !last_beat)
        begin
          next_st.beats_left = st.beats_left - 4'd1;
          next_st.half = 1'b1;
          next_st.ad_out = {32'h00000000, head.data[63:32]};
          next_st.cmd_out = `CMD_DATA_EOD;
        end
        else
        begin
          next_st.beats_left = st.beats_left - 4'd1;
          head_pop = 1'b1;
          next_st.valid = 1'b0;
          if (head.block && !last_beat && head_valid)
          begin
            next_st.state = st_wrdata; // Next line beat from buffer
          end
          else
          begin
            next_st.state = st_idle;
          end
          next_st.ad_out = head.data;
        end
      end
      st_slave:
      begin
        next_st.valid = 1'b0;
        next_st.drive = 1'b0;
        if (ext_bus_request_n && (agent_valid_n || sys_command_bus_in == `CMD_NULL))
        begin
          next_st.rel = 1'b0;
          next_st.state = st_idle;
        end
      end
      default:
      begin
        next_st.state = st_idle;
      end
    endcase
    next_st.wcount = st.wcount + {2'b00, wr_req_valid && wr_req_ready} - {2'b00, head_pop};
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule : sysif_bridge

//--- tb/sysif_bridge_chk.sv
`timescale 1ns/1ps
`include "sysif_regs.svh"
module sysif_chk
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [1:0]  cfg_write_mode,
  input wire logic        rd_req_ready,
  input wire logic        rd_data_valid,
  input wire logic [63:0] sys_addr_data_bus_out,
  input wire logic        sys_addr_data_bus_oe,
  input wire logic [8:0]  sys_command_bus_in,
  input wire logic [8:0]  sys_command_bus_out,
  input wire logic        read_accept_n,
  input wire logic        ext_bus_request_n,
  input wire logic        release_n,
  input wire logic        proc_valid_n,
  input wire logic        agent_valid_n
);
  logic beat_q;
  // Null carries no data, so it never counts as a beat
  always_ff @(posedge clk)
    beat_q <= !agent_valid_n && sys_command_bus_in[8] && sys_command_bus_in != `CMD_NULL;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd;
    !proc_valid_n && sys_command_bus_out[8:7] == 2'h0;
  endsequence
  sequence s_wr;
    !proc_valid_n && sys_command_bus_out[8:7] == 2'h1;
  endsequence
  a_valid_drives: assert property (!proc_valid_n |-> sys_addr_data_bus_oe)
    else $error("valid undriven");
  a_addr_holds: assert property (s_rd and read_accept_n |=> $stable(sys_addr_data_bus_out))
    else $error("address moved");
  a_rd_release: assert property (s_rd ##0 !read_accept_n |-> ##[1:4] !release_n)
    else $error("no release");
  a_rel_float: assert property (!release_n |-> !sys_addr_data_bus_oe)
    else $error("drives in slave");
  a_ext_release: assert property ($fell(ext_bus_request_n) |-> ##[1:60] !release_n)
    else $error("ext not served");
  a_data_cause: assert property (rd_data_valid |-> beat_q)
    else $error("data uncaused");
  a_one_request: assert property (s_rd |-> !rd_req_ready)
    else $error("second request");
  a_reissue_gap: assert property ((cfg_write_mode == `MODE_REISSUE) throughout s_wr
    |=> !(sys_command_bus_out[8:7] == 2'h1 && !proc_valid_n))
    else $error("write too close");
endmodule : sysif_chk
bind sysif_bridge sysif_chk sysif_chk_inst (.*);

//--- tb/agent_model.sv
`timescale 1ns/1ps
`include "sysif_regs.svh"
module agent_model
(
  input  wire logic        clk,
  input  wire logic        stall_wr,
  input  wire logic        ext_req,
  input  wire logic [3:0]  rd_beats,
  input  wire logic [63:0] sys_addr_data_bus_out,
  input  wire logic [8:0]  sys_command_bus_out,
  input  wire logic        proc_valid_n,
  input  wire logic        release_n,
  output logic [63:0]      sys_addr_data_bus_in,
  output logic [8:0]       sys_command_bus_in,
  output logic             read_accept_n,
  output logic             write_accept_n,
  output logic             ext_bus_request_n,
  output logic             agent_valid_n,
  output int               wr_beats
);
  logic       pend;
  logic [3:0] sent;
  initial
  begin
    {sys_addr_data_bus_in, sys_command_bus_in, pend, sent, wr_beats} = '0;
    {read_accept_n, write_accept_n, ext_bus_request_n, agent_valid_n} = 4'hF;
  end
  always @(posedge clk)
  begin
    read_accept_n <= stall_wr;
    write_accept_n <= stall_wr;
    ext_bus_request_n <= !ext_req;
    agent_valid_n <= 1'b1;
    // Idle bus toggles, so a stale word is never mistaken for data
    sys_addr_data_bus_in <= ~sys_addr_data_bus_in;
    sys_command_bus_in <= ~sys_command_bus_in;
    if (!proc_valid_n && sys_command_bus_out[8:7] == 2'h0)
      pend <= 1'b1;
    if (!proc_valid_n && sys_command_bus_out[8])
      wr_beats <= wr_beats + 1;
    if (!release_n && pend)
    begin
      agent_valid_n <= 1'b0;
      sys_addr_data_bus_in <= {32'hC3C3C3C3, 28'h0, sent};
      sys_command_bus_in <= (sent == rd_beats - 4'h1) ? `CMD_RESP_EOD : `CMD_RESP_DATA;
      sent <= (sent == rd_beats - 4'h1) ? 4'h0 : sent + 4'h1;
      pend <= (sent != rd_beats - 4'h1);
    end
    else if (!release_n && ext_req)
    begin
      agent_valid_n <= 1'b0;
      sys_command_bus_in <= `CMD_NULL;
    end
  end
endmodule : agent_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "sysif_regs.svh"
module tb_top;
  logic        clk, nrst, cfg_bus32, wr_req_valid, wr_req_ready, wr_req_block, rd_req_valid;
  logic        rd_req_ready, rd_req_block, rd_data_valid, rd_done, wbuf_empty, stall_wr;
  logic        sys_addr_data_bus_oe, sys_command_bus_oe, read_accept_n, write_accept_n;
  logic        ext_bus_request_n, release_n, proc_valid_n, agent_valid_n, ext_req;
  logic [1:0]  cfg_write_mode;
  logic [3:0]  wr_req_nbytes, rd_req_nbytes, rd_beats;
  logic [8:0]  sys_command_bus_in, sys_command_bus_out;
  logic [63:0] wr_req_addr, wr_req_data, rd_req_addr, rd_data, sys_addr_data_bus_in;
  logic [63:0] sys_addr_data_bus_out, got;
  int          err_count, checks, wr_beats, n, k, w0;
  sysif_bridge sysif_bridge_inst (.*);
  agent_model  agent_model_inst (.*);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] a, input logic [63:0] e, input string m);
  begin
    checks++;
    if (a !== e)
    begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  end
  endtask : chk
  task automatic finish_test();
  begin
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask : finish_test
  task automatic do_reset(input logic b32, input logic [1:0] md);
  begin
    {nrst, cfg_bus32, cfg_write_mode} <= {1'b0, b32, md};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
  end
  endtask : do_reset
  // Leaves valid high so back-to-back pushes never drive it twice in one step
  task automatic push(input logic [63:0] d, input logic blk);
  begin
    {wr_req_valid, wr_req_addr, wr_req_data, wr_req_nbytes, wr_req_block}
      <= {1'b1, 64'h1000, d, 4'h8, blk};
    @(posedge clk);
    for (n = 0; wr_req_ready !== 1'b1 && n < 50; n++)
      @(posedge clk);
  end
  endtask : push
  task automatic drain(input int beats);
  begin
    wr_req_valid <= 1'b0;
    for (n = 0; wbuf_empty !== 1'b1 && n < 300; n++)
      @(posedge clk);
    repeat (6) @(posedge clk);
    chk(wr_beats - w0, beats, "write beats");
  end
  endtask : drain
  task automatic t_fill();
  begin
    w0 = wr_beats;
    stall_wr <= 1'b1;
    k = 0;
    repeat (12)
    begin
      {wr_req_valid, wr_req_data, wr_req_block} <= {1'b1, 64'h55, 1'b0};
      @(posedge clk);
      k += (wr_req_ready === 1'b1);
    end
    chk(k, 4, "held entries");
    stall_wr <= 1'b0;
    drain(4);
  end
  endtask : t_fill
  task automatic t_read(input logic [3:0] beats, input logic blk);
  begin
    {rd_req_valid, rd_req_addr, rd_req_nbytes, rd_req_block, rd_beats, stall_wr}
      <= {1'b1, 64'h2000, 4'h8, blk, beats, 1'b1};
    @(posedge clk);
    for (n = 0; rd_req_ready !== 1'b1 && n < 50; n++)
      @(posedge clk);
    rd_req_valid <= 1'b0;
    // Accept withheld a while so the address must stand
    repeat (3) @(posedge clk);
    stall_wr <= 1'b0;
    k = 0;
    for (n = 0; n < 100 && rd_done !== 1'b1; n++)
    begin
      @(posedge clk);
      if (rd_data_valid === 1'b1)
      begin
        k++;
        got = rd_data;
      end
    end
    chk(k, beats, "read beats");
    chk(got[31:0], beats - 4'h1, "read data");
  end
  endtask : t_read
  task automatic t_ext();
  begin
    ext_req <= 1'b1;
    for (n = 0; release_n !== 1'b0 && n < 60; n++)
      @(posedge clk);
    chk(release_n, 1'b0, "no release");
    repeat (3) @(posedge clk);
    ext_req <= 1'b0;
    for (n = 0; release_n !== 1'b1 && n < 60; n++)
      @(posedge clk);
    chk(release_n, 1'b1, "bus not back");
  end
  endtask : t_ext
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, cfg_bus32, cfg_write_mode, wr_req_valid, rd_req_valid, wr_req_block} = '0;
    {rd_req_block, wr_req_addr, wr_req_data, rd_req_addr, wr_req_nbytes} = '0;
    {rd_req_nbytes, stall_wr, ext_req, rd_beats, err_count, checks} = '0;
    @(posedge clk);
    do_reset(1'b0, `MODE_COMPAT);
    w0 = wr_beats;
    push(64'h1122334455667788, 1'b0);
    drain(1);
    w0 = wr_beats;
    repeat (4) push(64'hA0, 1'b1);
    drain(4);
    t_fill();
    t_read(4'h1, 1'b0);
    t_read(4'h4, 1'b1);
    t_ext();
    do_reset(1'b1, `MODE_REISSUE);
    w0 = wr_beats;
    push(64'h0123456789ABCDEF, 1'b0);
    drain(2);
    t_read(4'h8, 1'b1);
    do_reset(1'b0, `MODE_PIPE);
    w0 = wr_beats;
    repeat (2) push(64'h77, 1'b0);
    drain(2);
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule : tb_top
